// *** pkg/frcs_pkg.sv ***
/*
  Constants of the fault record and settings block.
  Assumes one 100 MHz clock and a 16-bit register port.
*/
package frcs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int TRAFFIC_STEP_US  = 1000;
  localparam int TRAFFIC_STEP_CYC = TRAFFIC_STEP_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_INPUT_DISP = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_HIST0      = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_HIST_COUNT = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_ADDR_CODE  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_BAUD       = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_TRAFFIC    = 5'h0A;
  localparam logic [ADDR_W-1:0] OFS_PW_ENTRY   = 5'h0B;
  localparam logic [ADDR_W-1:0] OFS_BANK       = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CBF_TIME   = 5'h0D;
  localparam logic [ADDR_W-1:0] OFS_SWGROUP    = 5'h0E;
  localparam logic [ADDR_W-1:0] OFS_PW_VALUE   = 5'h0F;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 5'h11;
  localparam logic [ADDR_W-1:0] OFS_TEST       = 5'h12;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int ANGLE_W    = 9;
  localparam int HIST_DEPTH = 5;
  localparam int COUNT_W    = 3;
  localparam int CODE_W     = 8;
  localparam int SWG_W      = 8;
  localparam int CBF_W      = 10;
  localparam int TRAFFIC_W  = 8;
  localparam int TEST_W     = 4;

  localparam int WEIGHT_BLK1 = 0;
  localparam int WEIGHT_BLK2 = 1;
  localparam int WEIGHT_REMOTE_RESET_INPUT = 2;

  localparam int CBF_UNIT_MS = 10;
  localparam logic [CBF_W-1:0] CBF_MIN = 10'h00A;
  localparam logic [CBF_W-1:0] CBF_MAX = 10'h3E8;
  localparam logic [CBF_W-1:0] CBF_RST = 10'h014;

  localparam logic [CODE_W-1:0] ADDR_CODE_RST = 8'h00;
  localparam logic              BAUD_FAST_RST = 1'h1;
  localparam logic              BANK_RST      = 1'h0;
  localparam logic [SWG_W-1:0]  SWG_RST       = 8'h00;
  localparam logic [DATA_W-1:0] PW_RST        = 16'h0001;

  localparam int TEST_ENTER_BIT = 0;
  localparam int TEST_STEP_BIT  = 1;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int EV_W       = 3;
  localparam int EV_CAPTURE = 0;
  localparam int EV_REJECT  = 1;
  localparam int EV_CLEAR   = 2;

  typedef enum logic [1:0] {
    FRCS_TS_IDLE = 2'b01,
    FRCS_TS_RUN  = 2'b10
  } frcs_test_state_t;

endpackage : frcs_pkg

// *** logic/frcs_pin_sync.sv ***
/*
  Three-stage pin synchroniser.
  Assumes asynchronous pins; output follows once
  stages two and three agree.
*/
`timescale 1ns/1ps
module frcs_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // pins and clean levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_in)
    begin
      if (reset_in)
      begin
        s1_r[i]      <= 1'b0;
        s2_r[i]      <= 1'b0;
        s3_r[i]      <= 1'b0;
        level_out[i] <= 1'b0;
      end
      else
      begin
        s1_r[i] <= pin_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i])
        begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : frcs_pin_sync

// *** logic/frcs_history_stack.sv ***
/*
  Shift stack of recorded values, newest at entry 0.
  Assumes push and clear come from logic on clk_in; clear wins.
*/
`timescale 1ns/1ps
module frcs_history_stack
  import frcs_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int W     = ANGLE_W
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // control
  input  wire logic               clear_in,
  input  wire logic               push_in,
  input  wire logic [W-1:0]       data_in,
  // stored entries, entry 0 in the low bits
  output logic      [DEPTH*W-1:0] entry_out,
  output logic      [COUNT_W-1:0] count_out
);

  // ----------------------------------------------------------------
  // entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in)
    begin
      if (reset_in || clear_in)
      begin
        entry_out[i*W +: W] <= '0;
      end
      else if (push_in)
      begin
        if (i == 0)
        begin
          entry_out[i*W +: W] <= data_in;                 // see (R1)
        end
        else
        begin
          entry_out[i*W +: W] <= entry_out[(i-1)*W +: W]; // see (R2) see (R3)
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fill level, saturates at the depth
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in || clear_in)
    begin
      count_out <= '0;
    end
    else if (push_in && (count_out != COUNT_W'(DEPTH)))
    begin
      count_out <= count_out + 1'b1;
    end
  end

endmodule : frcs_history_stack

// *** logic/frcs_top.sv ***
/*
  Relay module records and communication settings:
  angle history, input display, test steps,
  password-guarded settings, masked interrupt.
  Assumes a register port on clk_in, asynchronous pins,
  and outside storage restoring settings after power loss.
*/
`timescale 1ns/1ps

// Notes on behaviour
// (R1) earth-fault operation pushes phase angle into five-deep stack
// (R2) older entries shift up one place on each capture
// (R3) a sixth capture drops the oldest entry
// (R4) input display: blocking one 1, blocking two 2, remote reset 4
// (R5) test mode from input display steps outputs one at a time
// (R6) address code selects this module on the shared bus
// (R7) baud selectable 4.8 or 9.6 kBd, defaulting to 9.6 kBd
// (R8) traffic monitor reads 0 when bus healthy, otherwise rolls 0 to 255
// (R9) setting writes need the correct password first, else rejected
// (R10) bank select 0 picks main settings, 1 second settings
// (R11) breaker-failure time settable 0.1 to 10 s, default 0.2 s
// (R12) switchgroup word defaults to zero
// (R13) both buttons together clear recorded registers
// (R14) supply loss also clears recorded registers
// (R15) settings survive supply loss
// (R16) newest capture reads first, older ones by age
module frcs_top
  import frcs_pkg::*;
#(
  parameter int TRAFFIC_CYC = TRAFFIC_STEP_CYC
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output logic      [DATA_W-1:0] rd_data_out,
  // protection events, same clock
  input  wire logic              ef_operate_in,
  input  wire logic [ANGLE_W-1:0] phase_angle_in,
  input  wire logic              bus_ok_in,
  // pins
  input  wire logic              blocking_input_one_in,
  input  wire logic              blocking_input_two_in,
  input  wire logic              remote_reset_input_in,
  input  wire logic              reset_button_in,
  input  wire logic              program_button_in,
  input  wire logic              supply_lost_in,
  // settings in force
  output logic      [CODE_W-1:0] module_addr_out,
  output logic                   baud_fast_out,
  output logic                   bank_second_out,
  output logic      [CBF_W-1:0]  breaker_failure_timer_out,
  output logic      [SWG_W-1:0]  config_switchgroup_out,
  // test drive and interrupt
  output logic      [TEST_W-1:0] test_signal_out,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_sync;
  wire        blk1_lvl   = pins_sync[0];
  wire        blk2_lvl   = pins_sync[1];
  wire        remote_reset_input_lvl   = pins_sync[2];
  wire        btn_rst    = pins_sync[3];
  wire        btn_prog   = pins_sync[4];
  wire        supply_off = pins_sync[5];

  frcs_pin_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .pin_in    ({supply_lost_in, program_button_in, reset_button_in,
                 remote_reset_input_in, blocking_input_two_in, blocking_input_one_in}),
    .level_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // record clearing
  // ----------------------------------------------------------------
  logic clear_req_d_r;
  wire  clear_req  = (btn_rst && btn_prog) || supply_off;   // see (R13) see (R14)
  wire  clear_edge = clear_req && !clear_req_d_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      clear_req_d_r <= 1'b0;
    end
    else
    begin
      clear_req_d_r <= clear_req;
    end
  end

  // ----------------------------------------------------------------
  // phase angle history
  // ----------------------------------------------------------------
  logic [HIST_DEPTH*ANGLE_W-1:0] hist_flat;
  logic [COUNT_W-1:0]            hist_count;
  wire                           capture = ef_operate_in && !clear_req;

  frcs_history_stack #(
    .DEPTH (HIST_DEPTH),
    .W     (ANGLE_W)
  ) u_hist (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clear_in  (clear_req),
    .push_in   (capture),                                   // see (R1)
    .data_in   (phase_angle_in),
    .entry_out (hist_flat),
    .count_out (hist_count)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] hist_ofs  = addr_in - OFS_HIST0;
  wire              hist_hit  = (addr_in >= OFS_HIST0) &&
                                (hist_ofs < ADDR_W'(HIST_DEPTH));
  wire [2:0]        hist_idx  = hist_ofs[2:0];
  wire [ANGLE_W-1:0] hist_word = hist_flat[hist_idx*ANGLE_W +: ANGLE_W]; // see (R16)

  wire is_setting = (addr_in == OFS_ADDR_CODE) || (addr_in == OFS_BAUD) ||
                    (addr_in == OFS_BANK)      || (addr_in == OFS_CBF_TIME) ||
                    (addr_in == OFS_SWGROUP)   || (addr_in == OFS_PW_VALUE);

  logic unlock_r;
  wire  wr_setting = wr_en_in && is_setting && unlock_r;    // see (R9)
  wire  wr_reject  = wr_en_in && is_setting && !unlock_r;   // see (R9)
  wire  wr_pw      = wr_en_in && (addr_in == OFS_PW_ENTRY);
  wire  wr_status  = wr_en_in && (addr_in == OFS_IRQ_STATUS);
  wire  wr_mask    = wr_en_in && (addr_in == OFS_IRQ_MASK);
  wire  wr_test    = wr_en_in && (addr_in == OFS_TEST);

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] password_r;
  wire  [CBF_W-1:0]  cbf_raw  = wr_data_in[CBF_W-1:0];
  wire  [CBF_W-1:0]  cbf_clip = (cbf_raw < CBF_MIN) ? CBF_MIN :
                                (cbf_raw > CBF_MAX) ? CBF_MAX : cbf_raw; // see (R11)

  // settings reset only with reset_in, never with clear_req
  always_ff @(posedge clk_in)
  begin
    if (reset_in)                                           // see (R15)
    begin
      module_addr_out           <= ADDR_CODE_RST;
      baud_fast_out             <= BAUD_FAST_RST;           // see (R7)
      bank_second_out           <= BANK_RST;
      breaker_failure_timer_out <= CBF_RST;                 // see (R11)
      config_switchgroup_out    <= SWG_RST;                 // see (R12)
      password_r                <= PW_RST;
    end
    else if (wr_setting)
    begin
      unique case (addr_in)
        OFS_ADDR_CODE: module_addr_out <= wr_data_in[CODE_W-1:0];       // see (R6)
        OFS_BAUD:      baud_fast_out   <= wr_data_in[0];                // see (R7)
        OFS_BANK:      bank_second_out <= wr_data_in[0];                // see (R10)
        OFS_CBF_TIME:  breaker_failure_timer_out <= cbf_clip;           // see (R11)
        OFS_SWGROUP:   config_switchgroup_out    <= wr_data_in[SWG_W-1:0]; // see (R12)
        default:       password_r      <= wr_data_in;
      endcase
    end
  end

  // unlock holds until a wrong password is entered
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      unlock_r <= 1'b0;
    end
    else if (wr_pw)
    begin
      unlock_r <= (wr_data_in == password_r);               // see (R9)
    end
  end

  // ----------------------------------------------------------------
  // bus traffic monitor
  // ----------------------------------------------------------------
  logic [$clog2(TRAFFIC_CYC)-1:0] div_r;
  logic                           tick_r;
  logic [TRAFFIC_W-1:0]           traffic_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in || div_r == ($clog2(TRAFFIC_CYC))'(TRAFFIC_CYC - 1))
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == ($clog2(TRAFFIC_CYC))'(TRAFFIC_CYC - 1));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in || bus_ok_in)
    begin
      traffic_r <= '0;                                      // see (R8)
    end
    else if (tick_r)
    begin
      traffic_r <= traffic_r + 1'b1;                        // see (R8)
    end
  end

  // ----------------------------------------------------------------
  // test sequencing
  // ----------------------------------------------------------------
  frcs_test_state_t test_state_r;
  logic             disp_sel_r;
  logic [TEST_W-1:0] test_nxt;
  wire  test_enter = wr_test && wr_data_in[TEST_ENTER_BIT] && disp_sel_r; // see (R5)
  wire  test_step  = wr_test && wr_data_in[TEST_STEP_BIT];

  // display register counts as selected after a read of it
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      disp_sel_r <= 1'b0;
    end
    else if (rd_en_in)
    begin
      disp_sel_r <= (addr_in == OFS_INPUT_DISP);
    end
  end

  always_comb
  begin
    test_nxt = test_signal_out;
    unique case (test_state_r)
      FRCS_TS_IDLE:
      begin
        if (test_enter)
        begin
          test_nxt = TEST_W'(1);
        end
      end
      FRCS_TS_RUN:
      begin
        if (test_step)
        begin
          test_nxt = test_signal_out << 1;                  // see (R5)
        end
      end
      default: test_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      test_signal_out <= '0;
      test_state_r    <= FRCS_TS_IDLE;
    end
    else
    begin
      test_signal_out <= test_nxt;
      test_state_r    <= (test_nxt != '0) ? FRCS_TS_RUN : FRCS_TS_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] events;
  wire  [EV_W-1:0] w1c       = wr_status ? wr_data_in[EV_W-1:0] : '0;
  wire  [EV_W-1:0] status_nxt = (status_r & ~w1c) | events;

  always_comb
  begin
    events             = '0;
    events[EV_CAPTURE] = capture;
    events[EV_REJECT]  = wr_reject;
    events[EV_CLEAR]   = clear_edge;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      status_r <= '0;
      mask_r   <= '0;
      irq_out  <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr_mask)
      begin
        mask_r <= wr_data_in[EV_W-1:0];
      end
      irq_out <= |(status_nxt & (wr_mask ? wr_data_in[EV_W-1:0] : mask_r));
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_nxt;
  wire  [2:0]        input_sum = {remote_reset_input_lvl, blk2_lvl, blk1_lvl}; // see (R4)

  always_comb
  begin
    rd_nxt = '0;
    if (hist_hit)
    begin
      rd_nxt[ANGLE_W-1:0] = hist_word;                      // see (R16)
    end
    else
    begin
      unique case (addr_in)
        OFS_INPUT_DISP: rd_nxt[2:0]           = input_sum;  // see (R4)
        OFS_HIST_COUNT: rd_nxt[COUNT_W-1:0]   = hist_count;
        OFS_ADDR_CODE:  rd_nxt[CODE_W-1:0]    = module_addr_out;
        OFS_BAUD:       rd_nxt[0]             = baud_fast_out;
        OFS_TRAFFIC:    rd_nxt[TRAFFIC_W-1:0] = traffic_r;
        OFS_PW_ENTRY:   rd_nxt[0]             = unlock_r;
        OFS_BANK:       rd_nxt[0]             = bank_second_out;
        OFS_CBF_TIME:   rd_nxt[CBF_W-1:0]     = breaker_failure_timer_out;
        OFS_SWGROUP:    rd_nxt[SWG_W-1:0]     = config_switchgroup_out;
        OFS_IRQ_STATUS: rd_nxt[EV_W-1:0]      = status_r;
        OFS_IRQ_MASK:   rd_nxt[EV_W-1:0]      = mask_r;
        OFS_TEST:       rd_nxt[TEST_W-1:0]    = test_signal_out;
        default:        rd_nxt                = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rd_data_out <= '0;
    end
    else if (rd_en_in)
    begin
      rd_data_out <= rd_nxt;
    end
    else
    begin
      rd_data_out <= '0;
    end
  end

endmodule : frcs_top

// *** verification/frcs_top_chk.sv ***
/*
  Port checks on frcs_top.
  Assumes a bind to frcs_top and a synchronous reset_in.
*/
`timescale 1ns/1ps
module frcs_top_chk
  import frcs_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              reset_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic              wr_en_in,
  input wire logic              rd_en_in,
  input wire logic [DATA_W-1:0] rd_data_out,
  input wire logic              ef_operate_in,
  input wire logic [ANGLE_W-1:0] phase_angle_in,
  input wire logic              blocking_input_one_in,
  input wire logic              blocking_input_two_in,
  input wire logic              remote_reset_input_in,
  input wire logic              supply_lost_in,
  input wire logic [CODE_W-1:0] module_addr_out,
  input wire logic              baud_fast_out,
  input wire logic              bank_second_out,
  input wire logic [CBF_W-1:0]  breaker_failure_timer_out,
  input wire logic [SWG_W-1:0]  config_switchgroup_out,
  input wire logic [TEST_W-1:0] test_signal_out
);
  // ----------------------------------------------------------------
  // port checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == '0)
    else $error("read data not idle");
  a_rst_dflt: assert property ($past(reset_in) |-> baud_fast_out == BAUD_FAST_RST
    && breaker_failure_timer_out == CBF_RST && config_switchgroup_out == SWG_RST)
    else $error("bad default");
  a_timer_range: assert property (breaker_failure_timer_out inside {[CBF_MIN:CBF_MAX]})
    else $error("timer range");
  a_test_onehot: assert property ($onehot0(test_signal_out))
    else $error("test not one-hot");
  a_set_keep: assert property (supply_lost_in && !wr_en_in |=> $stable({module_addr_out,
    baud_fast_out, bank_second_out, breaker_failure_timer_out, config_switchgroup_out}))
    else $error("setting lost");
  a_addr_read: assert property (rd_en_in && addr_in == OFS_ADDR_CODE |=>
    rd_data_out == DATA_W'(module_addr_out)) else $error("addr read");
  a_bank_read: assert property (rd_en_in && addr_in == OFS_BANK |=>
    rd_data_out == DATA_W'(bank_second_out)) else $error("bank read");
  a_cap_newest: assert property (ef_operate_in ##1 rd_en_in && addr_in == OFS_HIST0 |=>
    rd_data_out == DATA_W'($past(phase_angle_in, 2))) else $error("newest not first");
  a_input_sum: assert property ($stable({remote_reset_input_in, blocking_input_two_in,
    blocking_input_one_in})[*6] ##1 rd_en_in && addr_in == OFS_INPUT_DISP |=> rd_data_out ==
    DATA_W'({remote_reset_input_in, blocking_input_two_in, blocking_input_one_in}))
    else $error("bad input sum");
endmodule : frcs_top_chk

bind frcs_top frcs_top_chk u_chk (.*);

// *** verification/frcs_host_model.sv ***
/*
  Station controller: register port master.
  Assumes read data stand only in the cycle after the strobe.
*/
`timescale 1ns/1ps
module frcs_host_model
  import frcs_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // register port
  input  wire logic [DATA_W-1:0] rd_data_in,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wr_data_out,
  output logic                   wr_en_out,
  output logic                   rd_en_out
);
  initial {addr_out, wr_data_out, wr_en_out, rd_en_out} = '0;

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clk_in);
    wr_en_out   <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1 d = rd_data_in;
  endtask : rd_reg

  // password always precedes a setting change
  task automatic set_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr_reg(OFS_PW_ENTRY, PW_RST);
    wr_reg(a, d);
  endtask : set_reg
endmodule : frcs_host_model

// *** verification/tb_fault_record_and_comm_settings.sv ***
/*
  Self-checking bench for frcs_top via the host model.
  Assumes 100 MHz and a short traffic step.
*/
`timescale 1ns/1ps
module tb_fault_record_and_comm_settings
  import frcs_pkg::*;
;
  logic clk_in = 0, reset_in = 1, ef = 0, bus_ok = 1, blk1 = 0, blk2 = 0, remote_reset_input = 0;
  logic rst_btn = 0, prg_btn = 0, lost = 0, wr_en, rd_en, baud, bank, irq;
  logic [ANGLE_W-1:0] angle = '0;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdat, rdat, d;
  logic [CODE_W-1:0]  maddr;
  logic [CBF_W-1:0]   cbf;
  logic [SWG_W-1:0]   swg;
  logic [TEST_W-1:0]  tst;
  int error_cnt = 0, check_count = 0;

  initial forever #5 clk_in = ~clk_in;

  frcs_host_model u_host (.clk_in(clk_in), .rd_data_in(rdat), .addr_out(addr),
    .wr_data_out(wdat), .wr_en_out(wr_en), .rd_en_out(rd_en));

  frcs_top #(.TRAFFIC_CYC(8)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat),
    .ef_operate_in(ef), .phase_angle_in(angle), .bus_ok_in(bus_ok),
    .blocking_input_one_in(blk1), .blocking_input_two_in(blk2),
    .remote_reset_input_in(remote_reset_input), .reset_button_in(rst_btn), .program_button_in(prg_btn),
    .supply_lost_in(lost), .module_addr_out(maddr), .baud_fast_out(baud),
    .bank_second_out(bank), .breaker_failure_timer_out(cbf), .config_switchgroup_out(swg),
    .test_signal_out(tst), .irq_out(irq));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    u_host.rd_reg(a, d);
    check(d, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    settle(4);
    // ----------------------------------------------------------------
    // defaults and locked writes
    // ----------------------------------------------------------------
    check({baud, bank, cbf[5:0], swg}, {2'h2, CBF_RST[5:0], SWG_RST});
    u_host.wr_reg(OFS_ADDR_CODE, 16'h005A);
    rd(OFS_ADDR_CODE, 16'h0000);
    rd(OFS_IRQ_STATUS, 16'h0002);
    u_host.wr_reg(OFS_IRQ_MASK, 16'h0002);
    settle(2);
    check(DATA_W'(irq), 16'h0001);
    u_host.wr_reg(OFS_IRQ_STATUS, 16'h0002);
    settle(2);
    check(DATA_W'(irq), 16'h0000);
    $display("test defaults done");
    // ----------------------------------------------------------------
    // settings after password
    // ----------------------------------------------------------------
    u_host.set_reg(OFS_ADDR_CODE, 16'h005A);
    u_host.set_reg(OFS_BAUD, 16'h0000);
    u_host.set_reg(OFS_BANK, 16'h0001);
    u_host.set_reg(OFS_SWGROUP, 16'h00A5);
    u_host.set_reg(OFS_CBF_TIME, 16'h03FF);
    settle(1);
    check({maddr, swg}, 16'h5AA5);
    check(DATA_W'(baud), 16'h0000);
    check(DATA_W'(cbf), DATA_W'(CBF_MAX));
    rd(OFS_BANK, 16'h0001);
    u_host.set_reg(OFS_CBF_TIME, 16'h0005);
    rd(OFS_CBF_TIME, DATA_W'(CBF_MIN));
    rd(OFS_SWGROUP, 16'h00A5);
    rd(5'h1F, 16'h0000);
    $display("test settings done");
    // ----------------------------------------------------------------
    // input display sum
    // ----------------------------------------------------------------
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in);
      {remote_reset_input, blk2, blk1} <= 3'(i);
      settle(6);
      rd(OFS_INPUT_DISP, 16'(i));
    end
    $display("test inputs done");
    // ----------------------------------------------------------------
    // history stack, six captures back to back
    // ----------------------------------------------------------------
    for (int i = 1; i <= 6; i++)
    begin
      @(posedge clk_in);
      ef    <= 1'b1;
      angle <= 9'(i * 37);
    end
    fork
      u_host.rd_reg(OFS_HIST0, d);
      begin
        @(posedge clk_in);
        ef <= 1'b0;
      end
    join
    check(d, 16'd222);
    for (int k = 1; k < HIST_DEPTH; k++)
      rd(OFS_HIST0 + 5'(k), 16'((6 - k) * 37));
    rd(OFS_HIST_COUNT, 16'h0005);
    $display("test history done");
    // ----------------------------------------------------------------
    // clearing by buttons and by supply loss
    // ----------------------------------------------------------------
    @(posedge clk_in);
    {rst_btn, prg_btn} <= 2'b11;
    settle(6);
    {rst_btn, prg_btn} <= 2'b00;
    rd(OFS_HIST_COUNT, 16'h0000);
    rd(OFS_HIST0, 16'h0000);
    @(posedge clk_in);
    ef <= 1'b1;
    @(posedge clk_in);
    ef   <= 1'b0;
    lost <= 1'b1;
    settle(6);
    lost <= 1'b0;
    settle(6);
    rd(OFS_HIST_COUNT, 16'h0000);
    rd(OFS_ADDR_CODE, 16'h005A);
    rd(OFS_SWGROUP, 16'h00A5);
    $display("test clear done");
    // ----------------------------------------------------------------
    // bus traffic monitor
    // ----------------------------------------------------------------
    bus_ok <= 1'b0;
    settle(100);
    u_host.rd_reg(OFS_TRAFFIC, d);
    check(DATA_W'(d != 0), 16'h0001);
    bus_ok <= 1'b1;
    settle(2);
    rd(OFS_TRAFFIC, 16'h0000);
    $display("test traffic done");
    // ----------------------------------------------------------------
    // test mode stepping
    // ----------------------------------------------------------------
    rd(OFS_INPUT_DISP, 16'h0007);
    u_host.wr_reg(OFS_TEST, 16'h0001);
    settle(1);
    check(DATA_W'(tst), 16'h0001);
    for (int k = 1; k <= TEST_W; k++)
    begin
      u_host.wr_reg(OFS_TEST, 16'h0002);
      settle(1);
      check(DATA_W'(tst), 16'(k < TEST_W ? 1 << k : 0));
    end
    $display("test stepping done");
    print_verdict();
  end
endmodule : tb_fault_record_and_comm_settings
